// file: design/rprc_pkg.sv
`default_nettype none
package rprc_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // register map, byte addresses on the apb bus
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_GUIDE_SHORT = 8'h04;
  localparam logic [7:0] OFF_GUIDE_LONG = 8'h08;
  localparam logic [7:0] OFF_DATA_LOW_SHORT = 8'h0c;
  localparam logic [7:0] OFF_DATA_LOW_LONG = 8'h10;
  localparam logic [7:0] OFF_FRAME_END = 8'h14;
  localparam logic [7:0] OFF_DH0_SHORT = 8'h18;
  localparam logic [7:0] OFF_DH0_LONG = 8'h1c;
  localparam logic [7:0] OFF_DH1_SHORT = 8'h20;
  localparam logic [7:0] OFF_DH1_LONG = 8'h24;
  localparam logic [7:0] OFF_STATUS = 8'h28;
  localparam logic [7:0] OFF_MASK = 8'h2c;
  localparam logic [7:0] OFF_COUNT = 8'h30;

  // compare registers form one contiguous block of words
  localparam logic [7:0] OFF_CMP_FIRST = 8'h04;
  localparam logic [7:0] OFF_CMP_LAST = 8'h24;
  localparam int CMP_NUM = 9;

  ////////////////////////////////////////////////////////////////////////////
  // field positions
  localparam int CTRL_MODE_LSB = 0;
  localparam int CTRL_PRESC_LSB = 8;
  localparam int STAT_ERR_BIT = 0;
  localparam int STAT_GUIDE_BIT = 1;
  localparam int STAT_W = 2;
  localparam int COUNT_ARMED_BIT = 8;
  localparam int COUNT_RX_BIT = 9;

  ////////////////////////////////////////////////////////////////////////////
  // values after reset and counter limits
  localparam logic [7:0] CMP_RESET = 8'h00;
  localparam logic [7:0] PRESC_RESET = 8'h00;
  localparam logic [1:0] STAT_RESET = 2'h0;
  localparam logic [1:0] MASK_RESET = 2'h0;
  localparam logic [7:0] CNT_MAX = 8'hff;
  localparam logic [1:0] SYNC_RESET = 2'h0;

  ////////////////////////////////////////////////////////////////////////////
  // types
  typedef enum logic [1:0] {
    RPRC_MODE_OFF = 2'b00,
    RPRC_MODE_TYPEA = 2'b01,
    RPRC_MODE_TYPEB = 2'b10,
    RPRC_MODE_RSVD = 2'b11
  } rprc_mode_t;

  typedef enum logic {
    RPRC_ST_HUNT = 1'b0,
    RPRC_ST_ARMED = 1'b1
  } rprc_state_t;

  typedef struct packed {
    logic [7:0] guideHighShortCmp;
    logic [7:0] guideHighLongCmp;
    logic [7:0] dataLowShortCmp;
    logic [7:0] dataLowLongCmp;
    logic [7:0] frameEndCmp;
    logic [7:0] dataHighZeroShortCmp;
    logic [7:0] dataHighZeroLongCmp;
    logic [7:0] dataHighOneShortCmp;
    logic [7:0] dataHighOneLongCmp;
  } rprc_cmp_t;

  typedef struct packed {
    logic [7:0] prescale;
    rprc_mode_t mode;
  } rprc_ctrl_t;

endpackage
`default_nettype wire

// file: design/rprc_checker.sv
// Notes on behaviour
// - guide high lower bound register, 8 bits, writable, zero after reset
// - guide high upper bound register, 8 bits, writable, zero after reset
// - guide compares are used only in type A and type B modes
// - guide high accepted when lower bound <= count < upper bound
// - type A: error at rising edge if count below data low short bound
// - type A: error at rise if count >= low long and excess < end
// - type A: error at falling edge if count below high zero short bound
// - type A: error at fall if high zero long <= count < high one short
// - type A: error while input high once count reaches high one long
// - no error is raised before a valid guide pulse
// - after one error, no further error until the next valid guide
//
// Decided for this implementation: the placing of the registers and the APB register port.
`timescale 1ns/1ps
`default_nettype none
module rprc_checker (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output var logic [31:0] prdata,
  output var logic pready,
  output var logic pslverr,
  input wire logic remoteRxInput,
  output var logic remoteErrorIrq
);

  ////////////////////////////////////////////////////////////////////////////
  // address decoding shared by the read and write paths
  function automatic logic cmpHit(input logic [7:0] a);
    return (a >= rprc_pkg::OFF_CMP_FIRST) && (a <= rprc_pkg::OFF_CMP_LAST)
      && (a[1:0] == 2'h0);
  endfunction

  function automatic logic addrMapped(input logic [7:0] a);
    return cmpHit(a) || (a == rprc_pkg::OFF_CTRL)
      || (a == rprc_pkg::OFF_STATUS) || (a == rprc_pkg::OFF_MASK)
      || (a == rprc_pkg::OFF_COUNT);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // reset release: asynchronous assert, two-stage synchronous release
  logic [1:0] rstPipe_r;
  logic rstN;

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      rstPipe_r <= rprc_pkg::SYNC_RESET;
    end else begin
      rstPipe_r <= {rstPipe_r[0], 1'b1};
    end
  end

  assign rstN = rstPipe_r[1];

  ////////////////////////////////////////////////////////////////////////////
  // receive input synchroniser plus one stage for edge detection
  logic rxMeta_r;
  logic rxSync_r;
  logic rxPrev_r;

  always_ff @(posedge sys_clk or negedge rstN) begin
    if (!rstN) begin
      rxMeta_r <= 1'b0;
      rxSync_r <= 1'b0;
      rxPrev_r <= 1'b0;
    end else begin
      rxMeta_r <= remoteRxInput;
      rxSync_r <= rxMeta_r;
      rxPrev_r <= rxSync_r;
    end
  end

  // edges are seen two to three clocks after the pin moves
  logic riseEdge;
  logic fallEdge;
  logic anyEdge;
  assign riseEdge = rxSync_r & ~rxPrev_r;
  assign fallEdge = ~rxSync_r & rxPrev_r;
  assign anyEdge = riseEdge | fallEdge;

  ////////////////////////////////////////////////////////////////////////////
  // apb slave: one wait state, every answer comes from flip-flops
  logic pready_r;
  logic pslverr_r;
  logic [31:0] prdata_r;
  logic apbAccess;
  logic apbDone;
  logic addrOk;
  logic wrOk;
  logic [7:0] cmpOffs;
  logic [3:0] cmpIdx;
  logic [31:0] rdData;
  assign apbAccess = psel & penable;
  assign apbDone = apbAccess & pready_r;
  assign addrOk = addrMapped(paddr);
  assign wrOk = apbDone & pwrite & addrOk;
  assign cmpOffs = paddr - rprc_pkg::OFF_CMP_FIRST;
  assign cmpIdx = cmpOffs[5:2];
  // the response is built in the first access cycle and shown in the second
  always_ff @(posedge sys_clk or negedge rstN) begin
    if (!rstN) begin
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r <= 32'h0;
    end else begin
      pready_r <= apbAccess & ~pready_r;
      if (apbAccess && !pready_r) begin
        pslverr_r <= ~addrOk;
        prdata_r <= (pwrite || !addrOk) ? 32'h0 : rdData;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // control register: mode and counter prescale
  rprc_pkg::rprc_ctrl_t ctrl_r;
  logic wrCtrl;
  assign wrCtrl = wrOk & (paddr == rprc_pkg::OFF_CTRL);

  always_ff @(posedge sys_clk or negedge rstN) begin
    if (!rstN) begin
      ctrl_r.mode <= rprc_pkg::RPRC_MODE_OFF;
      ctrl_r.prescale <= rprc_pkg::PRESC_RESET;
    end else if (wrCtrl) begin
      ctrl_r.mode <= rprc_pkg::rprc_mode_t'(
        pwdata[rprc_pkg::CTRL_MODE_LSB +: 2]);
      ctrl_r.prescale <= pwdata[rprc_pkg::CTRL_PRESC_LSB +: 8];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // compare registers, one word each, low byte significant
  logic [7:0] cmp_r [0:rprc_pkg::CMP_NUM-1];
  rprc_pkg::rprc_cmp_t cmp;

  genvar gi;
  generate
    for (gi = 0; gi < rprc_pkg::CMP_NUM; gi++) begin : gCmp
      logic wrThis;
      assign wrThis = wrOk & cmpHit(paddr) & (cmpIdx == 4'(gi));
      always_ff @(posedge sys_clk or negedge rstN) begin
        if (!rstN) begin
          cmp_r[gi] <= rprc_pkg::CMP_RESET;
        end else if (wrThis) begin
          cmp_r[gi] <= pwdata[7:0];
        end
      end
    end
  endgenerate

  // index order of the block matches the struct from its top down
  assign cmp = {cmp_r[0], cmp_r[1], cmp_r[2], cmp_r[3], cmp_r[4],
                cmp_r[5], cmp_r[6], cmp_r[7], cmp_r[8]};

  ////////////////////////////////////////////////////////////////////////////
  // pulse-width counter with prescale, saturating so long levels stay long
  logic [7:0] div_r;
  logic [7:0] cnt_r;
  logic tick;
  logic [7:0] div_nxt;
  logic [7:0] cnt_nxt;
  // >= so that lowering the prescale never strands the divider above it
  assign tick = (div_r >= ctrl_r.prescale);
  assign div_nxt = (anyEdge || tick) ? 8'h00 : div_r + 8'h01;
  assign cnt_nxt = anyEdge ? 8'h00
    : (tick && cnt_r != rprc_pkg::CNT_MAX) ? cnt_r + 8'h01 : cnt_r;
  always_ff @(posedge sys_clk or negedge rstN) begin
    if (!rstN) begin
      div_r <= 8'h00;
      cnt_r <= 8'h00;
    end else begin
      div_r <= div_nxt;
      cnt_r <= cnt_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // guide pulse check, judged when the high level ends
  logic modeA;
  logic modeAB;
  logic guideOk;
  assign modeA = (ctrl_r.mode == rprc_pkg::RPRC_MODE_TYPEA);
  assign modeAB = modeA | (ctrl_r.mode == rprc_pkg::RPRC_MODE_TYPEB);
  assign guideOk = modeAB & fallEdge
    & (cnt_r >= cmp.guideHighShortCmp)
    & (cnt_r < cmp.guideHighLongCmp);

  ////////////////////////////////////////////////////////////////////////////
  // data pulse window checks for type A
  logic [7:0] lowExcess;
  logic errLowShort;
  logic errLowLong;
  logic errHighZero;
  logic errHighGap;
  logic errHighOne;
  logic errAny;
  assign lowExcess = cnt_r - cmp.dataLowLongCmp;
  assign errLowShort = riseEdge & (cnt_r < cmp.dataLowShortCmp);
  assign errLowLong = riseEdge & (cnt_r >= cmp.dataLowLongCmp)
    & (lowExcess < cmp.frameEndCmp);
  assign errHighZero = fallEdge
    & (cnt_r < cmp.dataHighZeroShortCmp);
  assign errHighGap = fallEdge
    & (cnt_r >= cmp.dataHighZeroLongCmp)
    & (cnt_r < cmp.dataHighOneShortCmp);
  assign errHighOne = rxSync_r
    & (cnt_r >= cmp.dataHighOneLongCmp);
  assign errAny = errLowShort | errLowLong | errHighZero | errHighGap
    | errHighOne;

  ////////////////////////////////////////////////////////////////////////////
  // frame state: armed by a good guide, disarmed by the first error
  rprc_pkg::rprc_state_t state_r;
  rprc_pkg::rprc_state_t state_nxt;
  logic armed;
  logic errEvt;
  assign armed = (state_r == rprc_pkg::RPRC_ST_ARMED);
  // a good guide starts a new frame and masks a falling-edge error with it
  assign errEvt = armed & modeA & ~guideOk & errAny;
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      rprc_pkg::RPRC_ST_HUNT: begin
        if (guideOk) begin
          state_nxt = rprc_pkg::RPRC_ST_ARMED;
        end
      end
      rprc_pkg::RPRC_ST_ARMED: begin
        if (!modeAB || errEvt) begin
          state_nxt = rprc_pkg::RPRC_ST_HUNT;
        end
      end
      default: begin
        state_nxt = rprc_pkg::RPRC_ST_HUNT;
      end
    endcase
  end

  always_ff @(posedge sys_clk or negedge rstN) begin
    if (!rstN) begin
      state_r <= rprc_pkg::RPRC_ST_HUNT;
    end else begin
      state_r <= state_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // sticky status, read clears; only bits actually returned are cleared,
  // so an event landing between capture and clear survives
  logic [1:0] status_r;
  logic [1:0] mask_r;
  logic [1:0] statClr;
  logic [1:0] statSet;
  logic [1:0] status_nxt;
  logic irq_r;
  logic wrMask;
  logic [1:0] mask_nxt;
  assign wrMask = wrOk & (paddr == rprc_pkg::OFF_MASK);
  assign mask_nxt = wrMask ? pwdata[rprc_pkg::STAT_W-1:0] : mask_r;
  assign statClr = (apbDone && !pwrite && paddr == rprc_pkg::OFF_STATUS)
    ? prdata_r[rprc_pkg::STAT_W-1:0] : 2'h0;
  assign statSet = {guideOk, errEvt};
  assign status_nxt = (status_r & ~statClr) | statSet;
  // irq uses the new mask too, so it never lags a mask write by a cycle
  always_ff @(posedge sys_clk or negedge rstN) begin
    if (!rstN) begin
      status_r <= rprc_pkg::STAT_RESET;
      mask_r <= rprc_pkg::MASK_RESET;
      irq_r <= 1'b0;
    end else begin
      status_r <= status_nxt;
      mask_r <= mask_nxt;
      irq_r <= |(status_nxt & mask_nxt);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read multiplexer
  assign rdData =
    (paddr == rprc_pkg::OFF_CTRL) ? {16'h0, ctrl_r.prescale, 6'h0,
      ctrl_r.mode} :
    cmpHit(paddr) ? {24'h0, cmp_r[cmpIdx]} :
    (paddr == rprc_pkg::OFF_STATUS) ? {30'h0, status_r} :
    (paddr == rprc_pkg::OFF_MASK) ? {30'h0, mask_r} :
    (paddr == rprc_pkg::OFF_COUNT) ? {22'h0, rxSync_r, armed, cnt_r} :
    32'h0;

  ////////////////////////////////////////////////////////////////////////////
  // outputs
  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign remoteErrorIrq = irq_r;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rstN);
  guide_low_bound_a:
  assert property ($rose(rstN) |-> cmp.guideHighShortCmp == 8'h00
    && cmp.guideHighLongCmp == 8'h00)
  else $error("guide bounds not zero after reset");
  guide_low_write_a:
  assert property ((wrOk && paddr == rprc_pkg::OFF_GUIDE_SHORT)
    |=> cmp.guideHighShortCmp == $past(pwdata[7:0]))
  else $error("guide lower bound write lost");
  guide_high_write_a:
  assert property ((wrOk && paddr == rprc_pkg::OFF_GUIDE_LONG)
    |=> cmp.guideHighLongCmp == $past(pwdata[7:0]) && $stable(cmp_r[0]))
  else $error("guide upper bound write lost");
  guide_mode_gate_a:
  assert property ($rose(status_r[rprc_pkg::STAT_GUIDE_BIT])
    |-> $past(modeAB) && $past(fallEdge))
  else $error("guide accepted outside type A or B");
  guide_window_a:
  assert property ((modeAB && fallEdge
    && cnt_r >= cmp.guideHighShortCmp && cnt_r < cmp.guideHighLongCmp)
    |=> status_r[rprc_pkg::STAT_GUIDE_BIT] && armed)
  else $error("guide in window not accepted");
  low_short_err_a:
  assert property ((armed && modeA && riseEdge
    && cnt_r < cmp.dataLowShortCmp)
    |=> status_r[rprc_pkg::STAT_ERR_BIT] && !armed)
  else $error("short data low not flagged");
  low_long_err_a:
  assert property ((armed && modeA && riseEdge
    && cnt_r >= cmp.dataLowLongCmp
    && 8'(cnt_r - cmp.dataLowLongCmp) < cmp.frameEndCmp)
    |=> status_r[rprc_pkg::STAT_ERR_BIT])
  else $error("long data low not flagged");
  high_zero_err_a:
  assert property ((armed && modeA && fallEdge && !guideOk
    && cnt_r < cmp.dataHighZeroShortCmp)
    |=> status_r[rprc_pkg::STAT_ERR_BIT])
  else $error("short data high not flagged");
  high_gap_err_a:
  assert property ((armed && modeA && fallEdge && !guideOk
    && cnt_r >= cmp.dataHighZeroLongCmp
    && cnt_r < cmp.dataHighOneShortCmp)
    |=> status_r[rprc_pkg::STAT_ERR_BIT])
  else $error("data high between windows not flagged");
  high_one_err_a:
  assert property ((armed && modeA && rxSync_r && !anyEdge
    && cnt_r >= cmp.dataHighOneLongCmp)
    |=> !armed ##0 status_r[rprc_pkg::STAT_ERR_BIT])
  else $error("overlong data high not flagged");
  no_early_err_a:
  assert property ($rose(status_r[rprc_pkg::STAT_ERR_BIT])
    |-> $past(state_r) == rprc_pkg::RPRC_ST_ARMED)
  else $error("error raised before valid guide");
  single_err_a:
  assert property (errEvt |=> !armed ##0 (!errEvt throughout
    (!guideOk)[*2]) or ##[0:1] guideOk)
  else $error("second error within one frame");
  count_restart_a:
  assert property (anyEdge |=> cnt_r == 8'h00 ##1 cnt_r <= 8'h01)
  else $error("counter not restarted at input edge");
  irq_level_a:
  assert property (remoteErrorIrq == |(status_r & mask_r))
  else $error("interrupt level disagrees with status and mask");
endmodule
`default_nettype wire

// file: verification/rprc_remote_model.sv
`timescale 1ns/1ps
`default_nettype none
// behavioural remote demodulator on the receive pin; idles low
module rprc_remote_model (
  input wire logic sys_clk,
  output var logic remoteRxInput
);
  initial remoteRxInput = 1'b0;

  ////////////////////////////////////////////////////////////////////////////
  // hold one level for n clocks; entered just after a rising edge
  task automatic hold(input logic v, input int n);
    remoteRxInput <= v;
    repeat (n) @(posedge sys_clk);
  endtask

  // guide high, one data low, one data high, then a long rest low;
  // the rest is long enough that the next rise never reads as data low
  task automatic frame(input int g, input int l1, input int h1);
    hold(1'b1, g);
    hold(1'b0, l1);
    hold(1'b1, h1);
    hold(1'b0, 60);
  endtask
endmodule
`default_nettype wire

// file: verification/rprc_checker_tb.sv
`timescale 1ns/1ps
`default_nettype none
module rprc_checker_tb;
  logic sys_clk = 1'b0;
  logic resetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  wire logic [31:0] prdata;
  wire logic pready;
  wire logic pslverr;
  wire logic remoteRxInput;
  wire logic remoteErrorIrq;
  logic [31:0] rd;
  logic er;
  int fails = 0;
  int checks = 0;
  // compare values: guide 100..120, data windows well apart from it
  logic [7:0] cv[9] = '{8'h64, 8'h78, 8'h0a, 8'h28, 8'h05, 8'h0a,
    8'h14, 8'h1e, 8'h3c};
  // ctrl per guide step: mode in the low bits, prescale 1 in the last two
  logic [15:0] gm[9] = '{16'h0, 16'h3, 16'h1, 16'h2, 16'h2, 16'h2, 16'h2,
    16'h102, 16'h102};
  int gh[9] = '{111, 111, 111, 101, 100, 120, 121, 200, 201};
  logic gx[9] = '{1'b0, 1'b0, 1'b1, 1'b1, 1'b0, 1'b1, 1'b0, 1'b0, 1'b1};
  int el[5] = '{6, 43, 21, 21, 21};
  int eh[5] = '{16, 16, 6, 26, 80};

  always #10 sys_clk = ~sys_clk;

  rprc_checker uut (
    .sys_clk(sys_clk),
    .resetn(resetn),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .remoteRxInput(remoteRxInput),
    .remoteErrorIrq(remoteErrorIrq)
  );

  rprc_remote_model rxModel (
    .sys_clk(sys_clk),
    .remoteRxInput(remoteRxInput)
  );

  ////////////////////////////////////////////////////////////////////////////
  task automatic stop_test;
    if (fails == 0 && checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp,
      input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      fails++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask

  // one apb transfer; waits on pready, bounded so a hang ends the run
  task automatic apb(input logic wr, input logic [7:0] a,
      input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    do begin
      @(posedge sys_clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      fails++;
      stop_test();
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge sys_clk);
  endtask

  task automatic rdchk(input string what, input logic [7:0] a,
      input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(what, exp, rd);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // reset values, 8-bit width of the guide compares, unmapped place
  task automatic t_regs;
    rdchk("guide short", rprc_pkg::OFF_GUIDE_SHORT, 32'h0);
    rdchk("guide long", rprc_pkg::OFF_GUIDE_LONG, 32'h0);
    apb(1'b1, rprc_pkg::OFF_GUIDE_SHORT, 32'h1234_56a5);
    apb(1'b1, rprc_pkg::OFF_GUIDE_LONG, 32'hffff_ff5a);
    rdchk("guide short", rprc_pkg::OFF_GUIDE_SHORT, 32'ha5);
    rdchk("guide long", rprc_pkg::OFF_GUIDE_LONG, 32'h5a);
    apb(1'b0, 8'h34, 32'h0);
    chk("unmapped err", 32'h1, {31'h0, er});
    chk("unmapped data", 32'h0, rd);
    for (int i = 0; i < 9; i++) begin
      apb(1'b1, rprc_pkg::OFF_CMP_FIRST + 8'(4 * i), {24'h0, cv[i]});
    end
  endtask

  // guide judged per mode and at both window edges (count = length - 1);
  // with prescale 1 the count is (length - 1) / 2, so 200 misses, 201 hits
  task automatic t_guide;
    for (int i = 0; i < 9; i++) begin
      apb(1'b1, rprc_pkg::OFF_CTRL, {16'h0, gm[i]});
      rxModel.hold(1'b1, gh[i]);
      rxModel.hold(1'b0, 60);
      rdchk("guide ok", rprc_pkg::OFF_STATUS,
        {30'h0, gx[i], 1'b0});
    end
  endtask

  // pass through off so no arming survives, then bad data with no guide
  task automatic t_noguide;
    apb(1'b1, rprc_pkg::OFF_CTRL, 32'h0);
    apb(1'b1, rprc_pkg::OFF_CTRL, 32'h1);
    rxModel.hold(1'b1, 6);
    rxModel.hold(1'b0, 6);
    rxModel.hold(1'b1, 6);
    rxModel.hold(1'b0, 60);
    rdchk("no guide", rprc_pkg::OFF_STATUS, 32'h0);
  endtask

  // one frame per error condition, then a second fault that must stay quiet
  task automatic t_errors;
    apb(1'b1, rprc_pkg::OFF_MASK, 32'h1);
    for (int i = 0; i < 5; i++) begin
      rxModel.frame(111, el[i], eh[i]);
      chk("irq set", 32'h1, {31'h0, remoteErrorIrq});
      apb(1'b1, rprc_pkg::OFF_MASK, 32'h0);
      chk("irq masked", 32'h0, {31'h0, remoteErrorIrq});
      apb(1'b1, rprc_pkg::OFF_MASK, 32'h1);
      chk("irq unmasked", 32'h1, {31'h0, remoteErrorIrq});
      rdchk("error", rprc_pkg::OFF_STATUS,
        32'h3);
      chk("irq cleared", 32'h0, {31'h0, remoteErrorIrq});
      rxModel.hold(1'b1, 6);
      rxModel.hold(1'b0, 60);
      rdchk("second error", rprc_pkg::OFF_STATUS, 32'h0);
    end
  endtask

  // in-window lows and highs after a guide raise nothing
  task automatic t_clean;
    rxModel.frame(111, 21, 41);
    rdchk("clean frame", rprc_pkg::OFF_STATUS, 32'h2);
    chk("irq quiet", 32'h0, {31'h0, remoteErrorIrq});
    apb(1'b0, rprc_pkg::OFF_COUNT, 32'h0);
    chk("count flags", 32'h100, rd & 32'h300);
    apb(1'b1, rprc_pkg::OFF_CTRL, 32'h0);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (6) @(posedge sys_clk);
    resetn <= 1'b1;
    repeat (3) @(posedge sys_clk);
    chk("irq reset", 32'h0, {31'h0, remoteErrorIrq});
    t_regs();
    t_guide();
    t_noguide();
    t_errors();
    t_clean();
    stop_test();
  end
endmodule
`default_nettype wire
